/* hdl/tae_alert_ctrl.sv */
// Configuration low byte, upper trip limit and alert pin control.
// Assumes a serial slave issues one-cycle register writes, holds the
// read address steady, and that rst is the power-on reset.
`include "tae_defs.svh"
module tae_alert_ctrl (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // Register access from the serial slave
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output tae_pkg::tae_word_t reg_rdata,
  // Sensor side
  input wire logic [15:0] temp_code,
  input wire logic [1:0] hyst_sel,
  input wire logic sensor_off,
  input wire logic [15:0] lower_limit,
  input wire logic [15:0] crit_limit,
  // Locks and write permits for the limit registers held outside
  output logic crit_limit_lock,
  output logic window_limits_lock,
  output logic crit_limit_wr,
  output logic lower_limit_wr,
  // Alert pin
  output logic alert_out,
  output logic alert_oe
);
  tae_pkg::tae_mode_t alert_latch_select;
  tae_pkg::tae_mode_t next_latch_select;
  tae_pkg::tae_word_t upper_limit_value;
  tae_pkg::tae_word_t next_upper;
  tae_pkg::tae_word_t next_rdata;
  logic alert_output_state;
  logic alert_output_enable;
  logic crit_only_select;
  logic alert_polarity;
  logic cond_q;
  logic latched;
  wire logic upper_alarm;
  wire logic lower_alarm;
  wire logic crit_alarm;

  function automatic logic tae_hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : tae_hit

  // Decode
  wire logic cfg_wr = reg_wr && tae_hit(reg_addr, `TAE_ADDR_CONFIG);
  wire logic upper_wr = reg_wr && tae_hit(reg_addr, `TAE_ADDR_UPPER);
  wire logic crit_wr = reg_wr && tae_hit(reg_addr, `TAE_ADDR_CRIT);
  wire logic lower_wr = reg_wr && tae_hit(reg_addr, `TAE_ADDR_LOWER);
  wire logic any_lock = crit_limit_lock || window_limits_lock;
  wire logic cfg_free = cfg_wr && !any_lock;
  wire logic crit_sel_free = cfg_wr && !window_limits_lock;

  // Locks can only be set; power-on reset is the sole way out
  wire logic next_crit_lock = crit_limit_lock ||
    (cfg_wr && reg_wdata[`TAE_CFG_CRIT_LOCK]);
  wire logic next_win_lock = window_limits_lock ||
    (cfg_wr && reg_wdata[`TAE_CFG_WIN_LOCK]);
  wire logic next_enable = cfg_free ? reg_wdata[`TAE_CFG_ENABLE]
                                    : alert_output_enable;
  wire logic next_polarity = cfg_free ? reg_wdata[`TAE_CFG_POLARITY]
                                      : alert_polarity;
  wire logic next_crit_only = crit_sel_free ? reg_wdata[`TAE_CFG_CRIT_ONLY]
                                            : crit_only_select;
  assign next_latch_select = cfg_free
    ? tae_pkg::tae_mode_t'(reg_wdata[`TAE_CFG_LATCH])
    : alert_latch_select;

  // Upper limit, reserved bits masked away on write
  assign next_upper = (upper_wr && !window_limits_lock)
    ? (reg_wdata & `TAE_LIMIT_MASK) : upper_limit_value;

  tae_limit_cmp u_cmp (
    .clk(clk),
    .rst(rst),
    .hold(sensor_off),
    .temp_code(temp_code),
    .hyst_sel(hyst_sel),
    .upper_limit(upper_limit_value),
    .lower_limit(lower_limit),
    .crit_limit(crit_limit),
    .upper_alarm(upper_alarm),
    .lower_alarm(lower_alarm),
    .crit_alarm(crit_alarm)
  );

  // Alarm condition and its rising edge, which is what latches
  wire logic cond = crit_only_select ? crit_alarm
    : (upper_alarm || lower_alarm || crit_alarm);
  wire logic cond_rise = cond && !cond_q;
  wire logic is_latch = alert_latch_select == tae_pkg::tae_latch;
  // The release bit is never stored, so it cannot read back
  wire logic alert_release = cfg_wr && reg_wdata[`TAE_CFG_RELEASE]
                             && is_latch;
  // A new trip in the release cycle wins over the release
  wire logic next_latched = (sensor_off || !is_latch) ? 1'b0
    : (alert_output_enable && cond_rise) ? 1'b1
    : alert_release ? 1'b0 : latched;
  wire logic next_state = (sensor_off || !alert_output_enable) ? 1'b0
    : is_latch ? next_latched : cond;
  // Active low releases the line when idle; active high drives both
  wire logic next_oe = !sensor_off &&
    (alert_polarity || next_state);
  wire logic next_out = alert_polarity && next_state;

  wire logic [7:0] cfg_low = {crit_limit_lock, window_limits_lock, 1'b0,
    alert_output_state, alert_output_enable, crit_only_select,
    alert_polarity, alert_latch_select};
  assign next_rdata = tae_hit(reg_addr, `TAE_ADDR_CONFIG) ? {8'h00, cfg_low}
    : tae_hit(reg_addr, `TAE_ADDR_UPPER) ? upper_limit_value
    : 16'h0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      crit_limit_lock <= 1'b0;
      window_limits_lock <= 1'b0;
      alert_output_enable <= 1'b0;
      crit_only_select <= 1'b0;
      alert_polarity <= 1'b0;
      alert_latch_select <= tae_pkg::tae_compare;
      upper_limit_value <= `TAE_UPPER_RESET;
    end else begin
      crit_limit_lock <= next_crit_lock;
      window_limits_lock <= next_win_lock;
      alert_output_enable <= next_enable;
      crit_only_select <= next_crit_only;
      alert_polarity <= next_polarity;
      alert_latch_select <= next_latch_select;
      upper_limit_value <= next_upper;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cond_q <= 1'b0;
      latched <= 1'b0;
      alert_output_state <= 1'b0;
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      cond_q <= cond;
      latched <= next_latched;
      alert_output_state <= next_state;
      alert_out <= next_out;
      alert_oe <= next_oe;
    end
  end

  // Permits are a cycle late so they leave a flop like every output
  always_ff @(posedge clk) begin
    if (rst) begin
      crit_limit_wr <= 1'b0;
      lower_limit_wr <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      crit_limit_wr <= crit_wr && !crit_limit_lock;
      lower_limit_wr <= lower_wr && !window_limits_lock;
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_crit_lock_sticky;
    crit_limit_lock |=> crit_limit_lock;
  endproperty
  a_crit_lock_sticky: assert property (p_crit_lock_sticky)
    else $error("critical lock cleared without reset");

  property p_crit_wr_blocked;
    crit_limit_lock |=> !crit_limit_wr;
  endproperty
  a_crit_wr_blocked: assert property (p_crit_wr_blocked)
    else $error("critical limit write passed while locked");

  property p_win_lock_set;
    (cfg_wr && reg_wdata[`TAE_CFG_WIN_LOCK]) |=> window_limits_lock [*3];
  endproperty
  a_win_lock_set: assert property (p_win_lock_set)
    else $error("window lock did not set and hold");

  property p_release_reads_zero;
    tae_hit(reg_addr, `TAE_ADDR_CONFIG) |=> !reg_rdata[`TAE_CFG_RELEASE];
  endproperty
  a_release_reads_zero: assert property (p_release_reads_zero)
    else $error("release bit read back as one");

  property p_release_drops;
    (alert_release && !cond_rise && !sensor_off) |=> !alert_output_state;
  endproperty
  a_release_drops: assert property (p_release_drops)
    else $error("latched alert not released");

  property p_state_pin;
    alert_output_state |-> (alert_oe && alert_out == $past(alert_polarity));
  endproperty
  a_state_pin: assert property (p_state_pin)
    else $error("status and alert pin disagree");

  property p_off_quiet;
    sensor_off |=> (!alert_output_state && !alert_oe);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("alert active during sensor-off");

  property p_disabled_quiet;
    !alert_output_enable |=> !alert_output_state;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("alert asserted while disabled");

  property p_cfg_locked;
    (cfg_wr && any_lock) |=> $stable(alert_output_enable)
      && $stable(alert_polarity) && $stable(alert_latch_select);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("locked config bits changed");

  property p_crit_only_locked;
    window_limits_lock |=> $stable(crit_only_select);
  endproperty
  a_crit_only_locked: assert property (p_crit_only_locked)
    else $error("critical-only bit changed under window lock");

  property p_upper_locked;
    window_limits_lock |=> $stable(upper_limit_value);
  endproperty
  a_upper_locked: assert property (p_upper_locked)
    else $error("upper limit changed under window lock");

  property p_upper_reserved;
    (upper_limit_value & ~`TAE_LIMIT_MASK) == 16'h0000;
  endproperty
  a_upper_reserved: assert property (p_upper_reserved)
    else $error("upper limit reserved bits set");

  property p_compare_follows;
    (!is_latch && alert_output_enable && !sensor_off)
      |=> alert_output_state == $past(cond);
  endproperty
  a_compare_follows: assert property (p_compare_follows)
    else $error("compare mode does not follow condition");

  property p_crit_only_masks;
    (crit_only_select && !crit_alarm && !is_latch) |=> !alert_output_state;
  endproperty
  a_crit_only_masks: assert property (p_crit_only_masks)
    else $error("non-critical alarm asserted in critical-only mode");

  property p_crit_only_write;
    crit_sel_free
      |=> crit_only_select == $past(reg_wdata[`TAE_CFG_CRIT_ONLY]);
  endproperty
  a_crit_only_write: assert property (p_crit_only_write)
    else $error("critical-only bit not written while unlocked");

  property p_cfg_write;
    cfg_free |=> alert_output_enable == $past(reg_wdata[`TAE_CFG_ENABLE])
      && alert_polarity == $past(reg_wdata[`TAE_CFG_POLARITY]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("enable or polarity not written while unlocked");

  property p_win_lock_sticky;
    window_limits_lock |=> window_limits_lock;
  endproperty
  a_win_lock_sticky: assert property (p_win_lock_sticky)
    else $error("window lock cleared without reset");

  property p_upper_write;
    (upper_wr && !window_limits_lock)
      |=> upper_limit_value == ($past(reg_wdata) & `TAE_LIMIT_MASK);
  endproperty
  a_upper_write: assert property (p_upper_write)
    else $error("upper limit write lost");

  property p_active_high_drives;
    (alert_polarity && !sensor_off) |=> alert_oe;
  endproperty
  a_active_high_drives: assert property (p_active_high_drives)
    else $error("active-high alert pin released");

  property p_active_low_out;
    !alert_polarity |=> !alert_out;
  endproperty
  a_active_low_out: assert property (p_active_low_out)
    else $error("active-low alert pin driven high");

  property p_latch_holds;
    (latched && is_latch && alert_output_enable && !alert_release
      && !sensor_off) |=> alert_output_state;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("latched alert dropped without release");

  c_latch_release: cover property (alert_release ##1 !alert_output_state);
  c_compare_trip: cover property (!is_latch ##1 alert_output_state);
  c_locked_write: cover property (cfg_wr && any_lock);
  c_window_lock: cover property (cfg_wr && reg_wdata[`TAE_CFG_WIN_LOCK]);
  c_sensor_off: cover property (alert_output_state ##1 sensor_off);
endmodule : tae_alert_ctrl

/* hdl/tae_defs.svh */
// Constants for the temperature alarm and alert-pin control block.
// Assumes the two-wire serial slave outside decodes the register
// pointer and presents plain register writes and reads.
//
// Contract
// - Config bit 7 locks the critical limit; set-only, cleared by reset.
// - Config bit 6 locks upper and lower limits; set-only, reset clears.
// - Config bit 5 is write-only, reads 0, self-clears; a 0 does nothing.
// - Writing 1 to bit 5 releases a latched alert; ignored in compare mode.
// - Config bit 4 reads 1 while the alert is asserted by a trip.
// - Bit 4 forced to 0 in sensor-off, updates again right after exit.
// - Config bit 3 enables the alert output; at 0 it never asserts.
// - Either lock set blocks writes to config bits 3, 1 and 0.
// - Config bit 2 at 1 lets only the critical alarm assert the alert.
// - Window lock set blocks writes to config bit 2.
// - Config bit 1 is polarity: 0 active low open drain, 1 active high.
// - Config bit 0 picks compare mode at 0, latch mode at 1.
// - Upper limit is a 16-bit register at 02h, 0.25 degree steps.
// - Enabled alert asserts above upper limit; clears at limit minus hyst.
// - Upper limit register is read-only while the window lock is set.
// - Upper bits 15:13 and 1:0 read 0; bit 12 sign; 11:2 value.
// - Upper sign bit is 0 for limits at or above zero, 1 below.
// - Hysteresis acts only on falling temperature.
// - Sensor-off raises no events and leaves the alert pin undriven.
`ifndef TAE_DEFS_SVH
`define TAE_DEFS_SVH

`define TAE_ADDR_CONFIG 8'h01
`define TAE_ADDR_UPPER 8'h02
`define TAE_ADDR_LOWER 8'h03
`define TAE_ADDR_CRIT 8'h04

`define TAE_CFG_CRIT_LOCK 7
`define TAE_CFG_WIN_LOCK 6
`define TAE_CFG_RELEASE 5
`define TAE_CFG_STATE 4
`define TAE_CFG_ENABLE 3
`define TAE_CFG_CRIT_ONLY 2
`define TAE_CFG_POLARITY 1
`define TAE_CFG_LATCH 0

`define TAE_LIMIT_MASK 16'h1FFC
`define TAE_LIMIT_SIGN 12
`define TAE_UPPER_RESET 16'h0000

// Hysteresis in eighths of a degree: off, 1.5, 3.0, 6.0
`define TAE_HYST_OFF 14'h0000
`define TAE_HYST_1P5 14'h000C
`define TAE_HYST_3P0 14'h0018
`define TAE_HYST_6P0 14'h0030

`endif

/* hdl/tae_pkg.sv */
// Types shared by the alarm control block.
// Assumes nothing of its surroundings.
package tae_pkg;
  typedef logic [15:0] tae_word_t;
  typedef enum logic {
    tae_compare = 1'b0,
    tae_latch = 1'b1
  } tae_mode_t;
endpackage : tae_pkg

/* hdl/tae_limit_cmp.sv */
// Trip-point comparators with falling-edge hysteresis.
// Assumes temperature and limits in register format, sign at bit 12.
`include "tae_defs.svh"
module tae_limit_cmp (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sensor side
  input wire logic hold,
  input wire logic [15:0] temp_code,
  input wire logic [1:0] hyst_sel,
  // Limits
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic [15:0] crit_limit,
  // Alarm flags
  output logic upper_alarm,
  output logic lower_alarm,
  output logic crit_alarm
);
  wire logic signed [13:0] temp_s;
  wire logic signed [13:0] hyst;
  wire logic signed [13:0] lower_s;
  wire logic [15:0] hi_limit [2];
  logic [1:0] hi_flag;
  wire logic [1:0] next_hi_flag;
  logic next_lower_alarm;

  // Limits are in quarter degrees; shift left once to match eighths
  function automatic logic signed [13:0] tae_lim(input logic [15:0] l);
    return {{2{l[12]}}, l[12:2], 1'b0};
  endfunction : tae_lim

  assign temp_s = {{2{temp_code[12]}}, temp_code[12:1]};
  assign hyst = (hyst_sel == 2'h1) ? `TAE_HYST_1P5 :
                (hyst_sel == 2'h2) ? `TAE_HYST_3P0 :
                (hyst_sel == 2'h3) ? `TAE_HYST_6P0 : `TAE_HYST_OFF;
  assign lower_s = tae_lim(lower_limit);
  assign hi_limit[0] = upper_limit;
  assign hi_limit[1] = crit_limit;

  // Rising limits: set above, clear only at limit minus hysteresis
  for (genvar i = 0; i < 2; i++) begin : g_high
    wire logic signed [13:0] lim_s;
    assign lim_s = tae_lim(hi_limit[i]);
    assign next_hi_flag[i] = hi_flag[i] ? !(temp_s <= lim_s - hyst)
                                        : (temp_s > lim_s);
  end

  // Lower limit: hysteresis below the trip, clear once back at limit
  assign next_lower_alarm = lower_alarm ? !(temp_s >= lower_s)
                                        : (temp_s < lower_s - hyst);

  // Data is frozen while the sensor is off
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_flag <= 2'h0;
      lower_alarm <= 1'b0;
    end else if (!hold) begin
      hi_flag <= next_hi_flag;
      lower_alarm <= next_lower_alarm;
    end
  end

  assign upper_alarm = hi_flag[0];
  assign crit_alarm = hi_flag[1];
endmodule : tae_limit_cmp

/* tb/tae_host.sv */
// Host model: issues register writes and reads as the serial slave would.
// Assumes clk from tb_top; the alert pin carries a pull-up.
module tae_host (
  // Clock
  input wire logic clk,
  // Register access
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Alert pin
  input wire logic alert_out,
  input wire logic alert_oe,
  output logic alert_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released pin is pulled to its inactive high level
  assign alert_pin = alert_oe ? alert_out : 1'b1;

  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Stale data must not look valid after the strobe
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : tae_host

/* tb/tb_top.sv */
// Self-checking bench for the alarm control block.
// Assumes the host model in tae_host; limits outside are held constant except one lower-limit change.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, reg_wr, sensor_off;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, temp_code, lower_limit, crit_limit;
  logic [1:0] hyst_sel;
  tae_pkg::tae_word_t reg_rdata;
  logic crit_lk, win_lk, crit_wr, low_wr, alert_out, alert_oe, pin;
  int mismatches = 0;
  int n_checks = 0;
  int n_crit_wr = 0;
  int n_low_wr = 0;

  tae_alert_ctrl i_tae_alert_ctrl (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .temp_code(temp_code), .hyst_sel(hyst_sel), .sensor_off(sensor_off),
    .lower_limit(lower_limit), .crit_limit(crit_limit),
    .crit_limit_lock(crit_lk), .window_limits_lock(win_lk),
    .crit_limit_wr(crit_wr), .lower_limit_wr(low_wr),
    .alert_out(alert_out), .alert_oe(alert_oe));
  tae_host i_tae_host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alert_out(alert_out),
    .alert_oe(alert_oe), .alert_pin(pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (crit_wr === 1'b1) n_crit_wr++;
    if (low_wr === 1'b1) n_low_wr++;
  end

  task automatic end_sim;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [15:0] exp);
    logic [15:0] d;
    i_tae_host.rd(a, d);
    chk(what, d, exp);
  endtask : rd_chk

  task automatic pin_chk(input logic p, input logic oe);
    chk("alert pin", 16'(pin), 16'(p));
    chk("alert_oe", 16'(alert_oe), 16'(oe));
  endtask : pin_chk

  // Comparator flop then output flop: two edges after an input change
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic temp(input logic [15:0] t);
    @(posedge clk);
    temp_code <= t;
    settle;
  endtask : temp

  task automatic t_reset;
    rd_chk("config", 8'h01, 16'h0000);
    rd_chk("upper", 8'h02, 16'h0000);
    pin_chk(1'b1, 1'b0);
  endtask : t_reset

  task automatic t_compare;
    i_tae_host.wr(8'h02, 16'hFFFF);
    rd_chk("upper", 8'h02, 16'h1FFC);
    rd_chk("unmapped", 8'h3F, 16'h0000);
    i_tae_host.wr(8'h02, 16'h0550);
    i_tae_host.wr(8'h01, 16'h0008);
    temp(16'h0560);
    pin_chk(1'b0, 1'b1);
    rd_chk("config", 8'h01, 16'h0018);
    i_tae_host.wr(8'h01, 16'h0028);
    rd_chk("config", 8'h01, 16'h0018);
    // 84 degrees is still above 85 minus 1.5
    temp(16'h0540);
    pin_chk(1'b0, 1'b1);
    temp(16'h0530);
    pin_chk(1'b1, 1'b0);
  endtask : t_compare

  task automatic t_latch;
    i_tae_host.wr(8'h01, 16'h000B);
    temp(16'h0560);
    pin_chk(1'b1, 1'b1);
    temp(16'h0100);
    pin_chk(1'b1, 1'b1);
    rd_chk("config", 8'h01, 16'h001B);
    i_tae_host.wr(8'h01, 16'h002B);
    rd_chk("config", 8'h01, 16'h000B);
    pin_chk(1'b0, 1'b1);
  endtask : t_latch

  task automatic t_crit_off;
    i_tae_host.wr(8'h01, 16'h000C);
    temp(16'h0560);
    pin_chk(1'b1, 1'b0);
    temp(16'h0620);
    pin_chk(1'b0, 1'b1);
    @(posedge clk);
    sensor_off <= 1'b1;
    settle;
    pin_chk(1'b1, 1'b0);
    rd_chk("config", 8'h01, 16'h000C);
    @(posedge clk);
    sensor_off <= 1'b0;
    settle;
    pin_chk(1'b0, 1'b1);
    rd_chk("config", 8'h01, 16'h001C);
    i_tae_host.wr(8'h01, 16'h0000);
    rd_chk("config", 8'h01, 16'h0000);
    pin_chk(1'b1, 1'b0);
  endtask : t_crit_off

  // Trip at 86 degrees, hold just above limit minus hysteresis, then drop
  task automatic trip_clear(input logic [1:0] hs, input logic [15:0] keep,
                            input logic [15:0] drop);
    @(posedge clk);
    hyst_sel <= hs;
    temp(16'h0560);
    pin_chk(1'b0, 1'b1);
    temp(keep);
    pin_chk(1'b0, 1'b1);
    temp(drop);
    pin_chk(1'b1, 1'b0);
  endtask : trip_clear

  task automatic t_hyst;
    i_tae_host.wr(8'h01, 16'h0008);
    trip_clear(2'h3, 16'h0500, 16'h04E0);
    trip_clear(2'h2, 16'h0528, 16'h0520);
    trip_clear(2'h0, 16'h0558, 16'h0550);
    // Lower limit of minus one degree checks the sign handling
    @(posedge clk);
    lower_limit <= 16'h1FF0;
    temp(16'h0100);
    pin_chk(1'b1, 1'b0);
    temp(16'h1FE0);
    pin_chk(1'b0, 1'b1);
    temp(16'h0100);
    pin_chk(1'b1, 1'b0);
  endtask : t_hyst

  task automatic t_locks;
    i_tae_host.wr(8'h04, 16'h0600);
    i_tae_host.wr(8'h03, 16'h0000);
    settle;
    chk("crit permits", 16'(n_crit_wr), 16'h0001);
    chk("lower permits", 16'(n_low_wr), 16'h0001);
    i_tae_host.wr(8'h01, 16'h0040);
    rd_chk("config", 8'h01, 16'h0040);
    i_tae_host.wr(8'h02, 16'h0200);
    rd_chk("upper", 8'h02, 16'h0550);
    i_tae_host.wr(8'h01, 16'h000F);
    rd_chk("config", 8'h01, 16'h0040);
    i_tae_host.wr(8'h01, 16'h0080);
    rd_chk("config", 8'h01, 16'h00C0);
    chk("crit lock", 16'(crit_lk), 16'h0001);
    chk("window lock", 16'(win_lk), 16'h0001);
    i_tae_host.wr(8'h03, 16'h0100);
    i_tae_host.wr(8'h04, 16'h0700);
    settle;
    chk("lower permits", 16'(n_low_wr), 16'h0001);
    chk("crit permits", 16'(n_crit_wr), 16'h0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk("config", 8'h01, 16'h0000);
    rd_chk("upper", 8'h02, 16'h0000);
    chk("crit lock", 16'(crit_lk), 16'h0000);
    chk("window lock", 16'(win_lk), 16'h0000);
  endtask : t_locks

  initial begin
    rst = 1'b1;
    temp_code = 16'h0100;
    hyst_sel = 2'h1;
    sensor_off = 1'b0;
    lower_limit = 16'h0000;
    crit_limit = 16'h0600;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_compare;
    t_latch;
    t_crit_off;
    t_hyst;
    t_locks;
    end_sim;
  end

  // Whole run is under two hundred cycles
  initial begin
    #100us;
    mismatches++;
    end_sim;
  end
endmodule : tb_top
